// File: verilog/spdr_pkg.sv
package spdr_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_WEIGHT = 16'h9C41;
    localparam logic [15:0] ADDR_STATUS = 16'h9C42;
    localparam logic [15:0] ADDR_TARE = 16'h9C49;
    localparam logic [15:0] ADDR_CMD = 16'h9C4A;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // status word fields, as controller bit numbers 1..16
    // ------------------------------------------------------------
    localparam int PLC_SP1 = 16;
    localparam int PLC_SP2 = 15;
    localparam int PLC_ZTOL = 14;
    localparam int PLC_PAR = 7;
    localparam int PLC_MOTION = 4;
    localparam int PLC_NET = 3;
    localparam int PLC_REFRESH = 2;
    localparam int PLC_VALID = 1;
    localparam int PLC_BITS = 16;

    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int CMD_SRC_LSB = 0;
    localparam int CMD_SRC_W = 3;
    localparam logic [2:0] SRC_GROSS = 3'h0;
    localparam logic [2:0] SRC_NET = 3'h1;
    localparam logic [2:0] SRC_DISP = 3'h2;
    localparam logic [2:0] SRC_TARE = 3'h3;
    localparam logic [2:0] SRC_SP1 = 3'h4;

    // ------------------------------------------------------------
    // setup values
    // ------------------------------------------------------------
    localparam logic FMT_INCREMENTS = 1'b0;
    localparam logic FMT_DIVISIONS = 1'b1;
    localparam logic [6:0] RACK_MIN = 7'h01;
    localparam logic [6:0] RACK_MAX = 7'h40;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PUB_IDLE = 3'b001,
        PUB_WEIGHT = 3'b010,
        PUB_STATUS = 3'b100
    } spdr_pub_t;

    // controller numbering runs the other way round
    function automatic int plc_pos(input int plc_bit);
        plc_pos = PLC_BITS - plc_bit;
    endfunction : plc_pos

    // drop implied decimal places to get whole divisions
    function automatic logic signed [15:0] to_div(
        input logic signed [15:0] w,
        input logic [1:0] places
    );
        case (places)
            2'h0: to_div = w;
            2'h1: to_div = w / 16'sh000A;
            2'h2: to_div = w / 16'sh0064;
            default: to_div = w / 16'sh03E8;
        endcase
    endfunction : to_div

endpackage : spdr_pkg

// File: verilog/spdr_wsel.sv
`timescale 1ns/10ps
module spdr_wsel
    import spdr_pkg::*;
(
    input wire logic [2:0] src_sel,
    input wire logic weight_format_select,
    input wire logic [1:0] dec_places,
    input wire logic scale_ok,
    input wire logic signed [15:0] gross_weight,
    input wire logic signed [15:0] net_weight,
    input wire logic signed [15:0] disp_weight,
    input wire logic signed [15:0] tare_weight,
    input wire logic signed [15:0] sp1_weight,
    output logic signed [15:0] weight_word
);
    import spdr_pkg::*;

    // ------------------------------------------------------------
    // source and format
    // ------------------------------------------------------------
    wire logic signed [15:0] picked;
    wire logic signed [15:0] formatted;

    assign picked = (src_sel == SRC_NET) ? net_weight :
                    (src_sel == SRC_DISP) ? disp_weight :
                    (src_sel == SRC_TARE) ? tare_weight :
                    (src_sel == SRC_SP1) ? sp1_weight : gross_weight;
    assign formatted = (weight_format_select == FMT_DIVISIONS) ?
                       to_div(picked, dec_places) : picked;
    assign weight_word = scale_ok ? formatted : WORD_RST;

endmodule : spdr_wsel

// File: verilog/spdr_regs.sv
// How it works
// - one quarter rack: two read words, two write words per scale
// - weight at 40001 and status at 40002 readable by controller
// - tare/setpoint at 40009 and command flags at 40010 writable
// - numeric words are 16-bit two's-complement; others are flag bits
// - weight bit n sits at word bit n
// - status bits 0,1,2: setpoint 1, setpoint 2, zero tolerance
// - status bit 9 shows the parallel input state
// - status bit 12 is motion, bit 13 is net mode
// - status bit 14 means refresh in progress, bit 15 weight valid
// - status bits 3-8, 10 and 11 read zero
// - controller bit 16 is position 0, bit 1 is position 15
// - format 0 gives increments, 1 gives whole divisions
// - answer only at a rack address of 1 to 64 that matches
// - global exchange off at 0, on at 1
// - motion and net mode read 1 when true
// - refresh flag set means reread; data was changing
// - valid only when scale ok; otherwise weight forced to zero
// - command bits 0-2 choose the reported weight source
`timescale 1ns/10ps
module spdr_regs
    import spdr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [6:0] req_rack,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [15:0] rsp_rdata,
    input wire logic weight_format_select,
    input wire logic [6:0] rack_address_setting,
    input wire logic global_exchange_select,
    input wire logic [1:0] dec_places,
    input wire logic weight_update,
    input wire logic scale_ok,
    input wire logic signed [15:0] gross_weight,
    input wire logic signed [15:0] net_weight,
    input wire logic signed [15:0] disp_weight,
    input wire logic signed [15:0] tare_weight,
    input wire logic signed [15:0] sp1_weight,
    input wire logic sp1_out,
    input wire logic sp2_out,
    input wire logic zero_tol_out,
    input wire logic motion,
    input wire logic net_mode,
    input wire logic parallel_input_pin,
    output logic signed [15:0] tare_value,
    output logic [15:0] cmd_flags,
    output logic [15:0] glb_weight,
    output logic [15:0] glb_status,
    output logic glb_strobe
);
    import spdr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spdr_pub_t pub_reg;
    spdr_pub_t pub_next;
    logic [15:0] weight_word_reg;
    logic [15:0] status_reg;
    logic signed [15:0] tare_value_reg;
    logic [15:0] command_flag_reg;
    logic refresh_reg;
    logic valid_hold_reg;
    logic published_reg;
    logic rsp_valid_reg;
    logic rsp_error_reg;
    logic [15:0] rsp_rdata_reg;
    logic [15:0] glb_weight_reg;
    logic [15:0] glb_status_reg;
    logic glb_strobe_reg;
    logic par_s1_reg;
    logic par_s2_reg;
    logic par_s3_reg;
    logic parallel_input_state;
    logic signed [15:0] sel_weight;

    // ------------------------------------------------------------
    // weight source
    // ------------------------------------------------------------
    spdr_wsel u_wsel (
        .src_sel(command_flag_reg[CMD_SRC_LSB +: CMD_SRC_W]),
        .weight_format_select(weight_format_select),
        .dec_places(dec_places),
        .scale_ok(scale_ok),
        .gross_weight(gross_weight),
        .net_weight(net_weight),
        .disp_weight(disp_weight),
        .tare_weight(tare_weight),
        .sp1_weight(sp1_weight),
        .weight_word(sel_weight)
    );

    // ------------------------------------------------------------
    // parallel input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            par_s1_reg <= 1'b0;
            par_s2_reg <= 1'b0;
            par_s3_reg <= 1'b0;
            parallel_input_state <= 1'b0;
        end
        else
        begin
            par_s1_reg <= parallel_input_pin;
            par_s2_reg <= par_s1_reg;
            par_s3_reg <= par_s2_reg;
            if (par_s2_reg == par_s3_reg)
                parallel_input_state <= par_s3_reg;
        end
    end

    // ------------------------------------------------------------
    // status assembly
    // ------------------------------------------------------------
    wire logic [15:0] status_next;
    assign status_next =
        (16'(sp1_out) << plc_pos(PLC_SP1)) |
        (16'(sp2_out) << plc_pos(PLC_SP2)) |
        (16'(zero_tol_out) << plc_pos(PLC_ZTOL)) |
        (16'(parallel_input_state) << plc_pos(PLC_PAR)) |
        (16'(motion) << plc_pos(PLC_MOTION)) |
        (16'(net_mode) << plc_pos(PLC_NET)) |
        (16'(valid_hold_reg) << plc_pos(PLC_VALID));

    wire logic [15:0] status_read;
    assign status_read = status_reg |
        (16'(refresh_reg) << plc_pos(PLC_REFRESH));

    // ------------------------------------------------------------
    // publish sequencer
    // ------------------------------------------------------------
    // weight and status land on different edges, so a read in
    // between sees the refresh flag and must be retried
    always_comb
    begin
        case (pub_reg)
            PUB_IDLE: pub_next = weight_update ? PUB_WEIGHT : PUB_IDLE;
            PUB_WEIGHT: pub_next = PUB_STATUS;
            PUB_STATUS: pub_next = PUB_IDLE;
            default: pub_next = PUB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pub_reg <= PUB_IDLE;
            weight_word_reg <= WORD_RST;
            status_reg <= WORD_RST;
            refresh_reg <= 1'b0;
            valid_hold_reg <= 1'b0;
            published_reg <= 1'b0;
        end
        else
        begin
            pub_reg <= pub_next;
            refresh_reg <= (pub_next != PUB_IDLE);
            if (pub_reg == PUB_WEIGHT)
            begin
                weight_word_reg <= sel_weight;
                valid_hold_reg <= scale_ok;
                published_reg <= 1'b1;
            end
            if (pub_reg == PUB_STATUS)
            begin
                status_reg <= status_next;
            end
        end
    end

    // ------------------------------------------------------------
    // global data copy
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            glb_weight_reg <= WORD_RST;
            glb_status_reg <= WORD_RST;
            glb_strobe_reg <= 1'b0;
        end
        else
        begin
            glb_strobe_reg <= (pub_reg == PUB_STATUS) &&
                              global_exchange_select;
            if ((pub_reg == PUB_STATUS) && global_exchange_select)
            begin
                glb_weight_reg <= weight_word_reg;
                glb_status_reg <= status_next;
            end
        end
    end

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    wire logic rack_ok;
    wire logic hit;
    wire logic is_rd_reg;
    wire logic is_wr_reg;
    wire logic acc_err;
    assign rack_ok = (rack_address_setting >= RACK_MIN) &&
                     (rack_address_setting <= RACK_MAX) &&
                     (req_rack == rack_address_setting);
    assign hit = req_valid && rack_ok;
    // two read and two write words
    assign is_rd_reg = (req_addr == ADDR_WEIGHT) ||
                       (req_addr == ADDR_STATUS);
    assign is_wr_reg = (req_addr == ADDR_TARE) || (req_addr == ADDR_CMD);
    assign acc_err = req_write ? !is_wr_reg : !is_rd_reg;

    wire logic [15:0] rd_mux;
    assign rd_mux = (req_addr == ADDR_WEIGHT) ? weight_word_reg :
                    (req_addr == ADDR_STATUS) ? status_read : WORD_RST;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tare_value_reg <= WORD_RST;
            command_flag_reg <= WORD_RST;
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
            rsp_rdata_reg <= WORD_RST;
        end
        else
        begin
            rsp_valid_reg <= hit;
            rsp_error_reg <= hit && acc_err;
            rsp_rdata_reg <= (hit && !req_write) ? rd_mux : WORD_RST;
            if (hit && req_write && (req_addr == ADDR_TARE))
                tare_value_reg <= req_wdata;
            if (hit && req_write && (req_addr == ADDR_CMD))
                command_flag_reg <= req_wdata;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_error = rsp_error_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign tare_value = tare_value_reg;
    assign cmd_flags = command_flag_reg;
    assign glb_weight = glb_weight_reg;
    assign glb_status = glb_status_reg;
    assign glb_strobe = glb_strobe_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_publish;
        refresh_reg ##1 refresh_reg ##1 !refresh_reg;
    endsequence

    property p_answer;
        @(posedge mclk) disable iff (!nrst)
        hit |=> rsp_valid_reg;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer at own rack");

    property p_foreign;
        @(posedge mclk) disable iff (!nrst)
        (req_valid && !rack_ok) |=> !rsp_valid_reg;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("answered foreign rack");

    property p_read_weight;
        @(posedge mclk) disable iff (!nrst)
        (hit && !req_write && req_addr == ADDR_WEIGHT) |=>
        (rsp_rdata_reg == $past(weight_word_reg));
    endproperty
    a_read_weight: assert property (p_read_weight)
        else $error("weight read mismatch");

    property p_unused;
        @(posedge mclk) disable iff (!nrst)
        (status_reg & 16'h0DF8) == WORD_RST;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused status bit set");

    property p_publish;
        @(posedge mclk) disable iff (!nrst)
        (pub_reg == PUB_IDLE && weight_update) |=> s_publish;
    endproperty
    a_publish: assert property (p_publish)
        else $error("refresh window wrong");

    property p_invalid_zero;
        @(posedge mclk) disable iff (!nrst)
        (pub_reg == PUB_IDLE && !status_reg[plc_pos(PLC_VALID)]) |->
        (weight_word_reg == WORD_RST);
    endproperty
    a_invalid_zero: assert property (p_invalid_zero)
        else $error("weight nonzero while invalid");

    property p_cmd_write;
        @(posedge mclk) disable iff (!nrst)
        (hit && req_write && req_addr == ADDR_CMD) |=>
        (command_flag_reg == $past(req_wdata));
    endproperty
    a_cmd_write: assert property (p_cmd_write)
        else $error("command write lost");

    property p_par_agree;
        @(posedge mclk) disable iff (!nrst)
        $changed(parallel_input_state) |->
        ($past(par_s2_reg) == $past(par_s3_reg));
    endproperty
    a_par_agree: assert property (p_par_agree)
        else $error("parallel input taken unsettled");

    property p_motion;
        @(posedge mclk) disable iff (!nrst)
        (pub_reg == PUB_STATUS) |=>
        (status_reg[plc_pos(PLC_MOTION)] == $past(motion));
    endproperty
    a_motion: assert property (p_motion)
        else $error("motion bit wrong");

    property p_reset_zero;
        @(posedge mclk) disable iff (!nrst)
        !published_reg |-> (weight_word_reg == WORD_RST &&
                            status_reg == WORD_RST);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("data before first publish");

endmodule : spdr_regs

// File: testbench/spdr_plc_model.sv
`timescale 1ns/10ps
module spdr_plc_model
(
    input wire logic mclk,
    output logic req_valid,
    output logic req_write,
    output logic [6:0] req_rack,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic [15:0] rsp_rdata
);
    import spdr_pkg::*;

    // ----
    // controller side
    // ----
    initial
    begin
        req_valid = 1'h0;
        {req_write, req_rack, req_addr, req_wdata} = 40'h0;
    end

    task automatic xfer(input logic wr, input logic [6:0] rk,
        input logic [15:0] a, input logic [15:0] wd, output logic g,
        output logic e, output logic [15:0] rd);
        int n;
        @(posedge mclk);
        #1;
        req_valid = 1'h1;
        {req_write, req_rack, req_addr, req_wdata} = {wr, rk, a, wd};
        @(posedge mclk);
        #1;
        req_valid = 1'h0;
        // idle lines flip, so a stale request never looks valid
        {req_write, req_rack, req_addr, req_wdata} = ~{wr, rk, a, wd};
        n = 0;
        g = rsp_valid;
        while (g !== 1'h1 && n < 3)
        begin
            @(posedge mclk);
            #1;
            g = rsp_valid;
            n++;
        end
        e = rsp_error;
        rd = rsp_rdata;
    endtask : xfer

    task automatic send_cmd(input logic [6:0] rk, input logic [15:0] tv,
        input logic [15:0] cf, output logic ok);
        logic g1, g2, e1, e2;
        logic [15:0] d;
        xfer(1'h1, rk, ADDR_TARE, tv, g1, e1, d);
        xfer(1'h1, rk, ADDR_CMD, cf, g2, e2, d);
        ok = g1 & g2 & ~e1 & ~e2;
    endtask : send_cmd

    task automatic rd_pair(input logic [6:0] rk, output logic [15:0] w,
        output logic [15:0] s);
        logic g, e;
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'h0, rk, ADDR_WEIGHT, 16'h0000, g, e, w);
            xfer(1'h0, rk, ADDR_STATUS, 16'h0000, g, e, s);
            if (s[14] !== 1'h1)
                break;
        end
    endtask : rd_pair
endmodule : spdr_plc_model

// File: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import spdr_pkg::*;

    logic mclk, nrst, req_valid, req_write, rsp_valid, rsp_error, glb_strobe;
    logic weight_format_select, global_exchange_select, weight_update;
    logic scale_ok, sp1_out, sp2_out, zero_tol_out, motion, net_mode;
    logic parallel_input_pin;
    logic [1:0] dec_places;
    logic [6:0] req_rack, rack_address_setting;
    logic [15:0] req_addr, req_wdata, rsp_rdata, cmd_flags, glb_weight;
    logic [15:0] glb_status;
    logic signed [15:0] gross_weight, net_weight, disp_weight;
    logic signed [15:0] tare_weight, sp1_weight, tare_value;
    int err_count = 0;
    int samples_checked = 0;
    int n_strobe = 0;

    spdr_regs dut_u (.mclk(mclk), .nrst(nrst), .req_valid(req_valid),
        .req_write(req_write), .req_rack(req_rack), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_rdata(rsp_rdata), .weight_format_select(weight_format_select),
        .rack_address_setting(rack_address_setting),
        .global_exchange_select(global_exchange_select),
        .dec_places(dec_places), .weight_update(weight_update),
        .scale_ok(scale_ok), .gross_weight(gross_weight),
        .net_weight(net_weight), .disp_weight(disp_weight),
        .tare_weight(tare_weight), .sp1_weight(sp1_weight),
        .sp1_out(sp1_out), .sp2_out(sp2_out), .zero_tol_out(zero_tol_out),
        .motion(motion), .net_mode(net_mode),
        .parallel_input_pin(parallel_input_pin), .tare_value(tare_value),
        .cmd_flags(cmd_flags), .glb_weight(glb_weight),
        .glb_status(glb_status), .glb_strobe(glb_strobe));

    spdr_plc_model plc_u (.mclk(mclk), .req_valid(req_valid),
        .req_write(req_write), .req_rack(req_rack), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));

    // ----
    // helpers
    // ----
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (glb_strobe === 1'h1)
            n_strobe <= n_strobe + 1;

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk_w(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_w

    task automatic chk_b(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : chk_b

    // a lost answer is given up after three more cycles and would throw off every later check, so stop at once
    task automatic acc(input logic wr, input logic [15:0] a,
        input logic [15:0] wd, input logic ee, output logic [15:0] d);
        logic g, e;
        plc_u.xfer(wr, rack_address_setting, a, wd, g, e, d);
        chk_b("answer", 1'h1, g);
        chk_b("error", ee, e);
        if (g !== 1'h1)
            tally_and_finish();
    endtask : acc

    task automatic rdw(input logic [15:0] a, input logic [15:0] ex,
        input string nm);
        logic [15:0] d;
        acc(1'h0, a, 16'h0000, 1'h0, d);
        chk_w(nm, ex, d);
    endtask : rdw

    task automatic pub;
        @(posedge mclk);
        #1;
        weight_update = 1'h1;
        @(posedge mclk);
        #1;
        weight_update = 1'h0;
        repeat (4) @(posedge mclk);
        #1;
    endtask : pub

    function automatic logic [15:0] exp_st();
        return {scale_ok, 1'h0, net_mode, motion, 2'h0, parallel_input_pin,
            6'h00, zero_tol_out, sp2_out, sp1_out};
    endfunction : exp_st

    // ----
    // scenarios
    // ----
    task automatic t_reset;
        chk_w("tare_value", 16'h0000, tare_value);
        chk_w("cmd_flags", 16'h0000, cmd_flags);
        rdw(ADDR_WEIGHT, 16'h0000, "weight");
        rdw(ADDR_STATUS, 16'h0000, "status");
    endtask : t_reset

    task automatic t_access;
        logic [15:0] d;
        logic ok;
        acc(1'h1, ADDR_WEIGHT, 16'h1234, 1'h1, d);
        acc(1'h1, ADDR_STATUS, 16'h1234, 1'h1, d);
        acc(1'h0, ADDR_TARE, 16'h0000, 1'h1, d);
        acc(1'h0, ADDR_CMD, 16'h0000, 1'h1, d);
        acc(1'h0, 16'h9C43, 16'h0000, 1'h1, d);
        plc_u.send_cmd(rack_address_setting, 16'h8001, 16'hFFF8, ok);
        chk_b("cmd_ok", 1'h1, ok);
        chk_w("tare_value", 16'h8001, tare_value);
        chk_w("cmd_flags", 16'hFFF8, cmd_flags);
        rdw(ADDR_WEIGHT, 16'h0000, "weight");
    endtask : t_access

    task automatic t_select;
        logic signed [15:0] ew;
        logic ok;
        for (int s = 0; s < 8; s++)
        begin
            plc_u.send_cmd(rack_address_setting, 16'h0000, 16'(s), ok);
            pub();
            case (s)
                1: ew = net_weight;
                2: ew = disp_weight;
                3: ew = tare_weight;
                4: ew = sp1_weight;
                default: ew = gross_weight;
            endcase
            rdw(ADDR_WEIGHT, ew, "weight");
        end
    endtask : t_select

    task automatic t_rack;
        logic [6:0] st[6] = '{7'h05, 7'h05, 7'h00, 7'h40, 7'h41, 7'h01};
        logic [6:0] rq[6] = '{7'h05, 7'h06, 7'h00, 7'h40, 7'h41, 7'h01};
        logic an[6] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
        logic g, e;
        logic [15:0] d;
        plc_u.xfer(1'h1, 7'h06, ADDR_CMD, 16'h0004, g, e, d);
        chk_b("answer", 1'h0, g);
        chk_w("cmd_flags", 16'h0007, cmd_flags);
        for (int i = 0; i < 6; i++)
        begin
            rack_address_setting = st[i];
            plc_u.xfer(1'h0, rq[i], ADDR_WEIGHT, 16'h0000, g, e, d);
            chk_b("answer", an[i], g);
        end
        rack_address_setting = 7'h05;
    endtask : t_rack

    task automatic t_format;
        logic signed [15:0] dv[4] = '{16'sh0001, 16'sh000A, 16'sh0064,
            16'sh03E8};
        weight_format_select = FMT_DIVISIONS;
        for (int d = 0; d < 4; d++)
        begin
            dec_places = 2'(d);
            pub();
            rdw(ADDR_WEIGHT, gross_weight / dv[d], "div");
        end
        weight_format_select = FMT_INCREMENTS;
        pub();
        rdw(ADDR_WEIGHT, gross_weight, "inc");
    endtask : t_format

    task automatic t_status;
        logic [5:0] p;
        for (int i = 0; i < 7; i++)
        begin
            p = (i < 6) ? 6'(1 << i) : 6'h3F;
            {net_mode, motion, parallel_input_pin} = p[5:3];
            {zero_tol_out, sp2_out, sp1_out} = p[2:0];
            scale_ok = i[0];
            repeat (6) @(posedge mclk);
            pub();
            rdw(ADDR_STATUS, exp_st(), "st");
            rdw(ADDR_WEIGHT, scale_ok ? gross_weight : 16'h0, "w");
        end
        scale_ok = 1'h1;
    endtask : t_status

    task automatic t_refresh;
        logic [15:0] d, w;
        fork
            pub();
            begin
                repeat (2) @(posedge mclk);
                acc(1'h0, ADDR_STATUS, 16'h0000, 1'h0, d);
            end
        join
        chk_b("refresh", 1'h1, d[14]);
        plc_u.rd_pair(rack_address_setting, w, d);
        chk_b("refresh", 1'h0, d[14]);
        chk_w("weight", gross_weight, w);
    endtask : t_refresh

    task automatic t_global;
        int k;
        k = n_strobe;
        pub();
        chk_w("strobes", 16'(k), 16'(n_strobe));
        global_exchange_select = 1'h1;
        pub();
        chk_w("strobes", 16'(k + 1), 16'(n_strobe));
        chk_w("glb_weight", gross_weight, glb_weight);
        chk_w("glb_status", exp_st(), glb_status);
    endtask : t_global

    // reset again once data and commands are loaded
    task automatic t_rereset;
        @(posedge mclk);
        #1;
        nrst = 1'h0;
        repeat (2) @(posedge mclk);
        #1;
        nrst = 1'h1;
        t_reset();
        chk_b("glb_strobe", 1'h0, glb_strobe);
    endtask : t_rereset

    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        nrst = 1'h0;
        {weight_format_select, global_exchange_select} = 2'h0;
        {weight_update, dec_places, scale_ok} = 4'h1;
        rack_address_setting = 7'h05;
        gross_weight = 16'hFB2E;
        net_weight = 16'h0123;
        disp_weight = 16'h7FFF;
        tare_weight = 16'h8000;
        sp1_weight = 16'h0055;
        {sp1_out, sp2_out, zero_tol_out} = 3'h0;
        {motion, net_mode, parallel_input_pin} = 3'h0;
        repeat (12) @(posedge mclk);
        #1;
        nrst = 1'h1;
        t_reset();
        t_access();
        t_select();
        t_rack();
        t_format();
        t_status();
        t_refresh();
        t_global();
        t_rereset();
        tally_and_finish();
    end
endmodule : tb_top
